// ==== logic/serial_irq_source_select.sv ====
// Top: per-channel selection of logical device interrupts onto the serial IRQ slots
// Overview of operation
// - Bit 7 picks first or second line
// - Single-line devices ignore the line choice
// - Bits 5:0 pick the source logical device
// - Device 0Ch gives firmware-driven host interrupt
// - Sixteen independently configurable channels
// - Entry FFh keeps channel deactivated
module serial_irq_source_select
    import sirq_pkg::*;
#(
    parameter int N = CHANNELS,
    parameter logic [DEVICES-1:0] TWO_LINE_DEVICES = 64'h0000_0000_0000_0002
) (
    // Clock and resets
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic host_side_reset_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Logical device interrupt lines
    input wire logic [DEVICES-1:0] dev_irq_first,
    input wire logic [DEVICES-1:0] dev_irq_second,
    // Slot levels toward the serial IRQ framer
    output logic [N-1:0] irq_slot_active
);

    // ==========================================================
    // Request decode
    reg_req_type req;

    logic chan_hit;
    logic fw_lo_hit;
    logic fw_hi_hit;

    logic chan_wr;
    logic fw_lo_wr;
    logic fw_hi_wr;
    logic [3:0] chan_idx;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign chan_idx = req.addr[3:0];

    // Offsets outside the map decode to no hit, so writes there are lost
    always_comb begin
        chan_hit = 1'b0;
        fw_lo_hit = 1'b0;
        fw_hi_hit = 1'b0;
        if ((req.addr >= CHAN_BASE) && (req.addr <= CHAN_LAST)) begin
            chan_hit = 1'b1;
        end
        if (req.addr == FW_IRQ_OFS) begin
            fw_lo_hit = 1'b1;
        end
        if (req.addr == FW_IRQ_OFS + 8'h01) begin
            fw_hi_hit = 1'b1;
        end
    end

    assign chan_wr = req.wr && chan_hit;
    assign fw_lo_wr = req.wr && fw_lo_hit;
    assign fw_hi_wr = req.wr && fw_hi_hit;

    // ==========================================================
    // Channel storage
    chan_entry_type [N-1:0] entries;

    // Sixteen independent entries
    // Its own read port lags a cycle, so reads take the live entries instead
    sirq_chan_mem #(.N(N)) u_mem (
        .sys_clk(sys_clk),
        .host_side_reset_n(host_side_reset_n),
        .wr_en(chan_wr),
        .wr_idx(chan_idx),
        .wr_data(req.wdata),
        .rd_idx(chan_idx),
        .rd_data(),
        .entries(entries)
    );

    // ==========================================================
    // Firmware interrupt register
    logic [N-1:0] fw_irq_r;
    logic [N-1:0] fw_irq_nxt;

    // Firmware raises its slots through these bits
    // Each byte lands on its own, so a half update is live at once
    generate
        for (genvar g = 0; g < N; g++) begin : g_fw
            always_comb begin
                fw_irq_nxt[g] = fw_irq_r[g];
                if ((g < 8) && fw_lo_wr) begin
                    fw_irq_nxt[g] = req.wdata[g % 8];
                end
                if ((g >= 8) && (g < 16) && fw_hi_wr) begin
                    fw_irq_nxt[g] = req.wdata[g % 8];
                end
            end
        end
    endgenerate

    // Firmware bits follow the host-side reset like the channel entries
    always_ff @(posedge sys_clk or negedge host_side_reset_n) begin
        if (!host_side_reset_n) begin
            fw_irq_r <= '0;
        end else begin
            fw_irq_r <= fw_irq_nxt;
        end
    end

    // ==========================================================
    // Read path
    typedef enum logic [1:0] {
        RD_NONE,
        RD_CHAN,
        RD_FW_LO,
        RD_FW_HI
    } rd_src_type;

    rd_src_type rd_src;
    logic [7:0] fw_lo_view;
    logic [7:0] fw_hi_view;
    logic [7:0] rdata_nxt;

    assign fw_lo_view = fw_irq_r[7:0];
    assign fw_hi_view = fw_irq_r[N-1:8];

    always_comb begin
        rd_src = RD_NONE;
        if (req.rd && chan_hit) begin
            rd_src = RD_CHAN;
        end else if (req.rd && fw_lo_hit) begin
            rd_src = RD_FW_LO;
        end else if (req.rd && fw_hi_hit) begin
            rd_src = RD_FW_HI;
        end
    end

    // Unmapped offsets and idle cycles read as zero
    always_comb begin
        case (rd_src)
            RD_CHAN: rdata_nxt = 8'(entries[chan_idx]);
            RD_FW_LO: rdata_nxt = fw_lo_view;
            RD_FW_HI: rdata_nxt = fw_hi_view;
            default: rdata_nxt = UNMAPPED_READ;
        endcase
    end

    // Registered so the read data stand one cycle and then fall back to zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= UNMAPPED_READ;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // ==========================================================
    // Routing
    logic [N-1:0] slot_nxt;

    generate
        for (genvar g = 0; g < N; g++) begin : g_route
            logic [DEV_W-1:0] dev;
            logic use_second;
            logic line_level;
            logic from_fw;
            logic picked;
            logic located;
            logic parked;
            logic enabled;

            always_comb begin
                dev = entries[g].device;

                use_second = entries[g].line_sel && TWO_LINE_DEVICES[dev];
                if (use_second) begin
                    line_level = dev_irq_second[dev];
                end else begin
                    line_level = dev_irq_first[dev];
                end

                from_fw = (dev == FW_DEVICE);
                if (from_fw) begin
                    picked = fw_irq_r[g];
                end else begin
                    picked = line_level;
                end

                located = !entries[g].location;
                // FFh deactivates
                // Kept explicit although FFh also has bit 6 set
                parked = (entries[g] == chan_entry_type'(CHAN_RESET));
                enabled = located && !parked;

                slot_nxt[g] = enabled && picked;
            end
        end
    endgenerate

    // ==========================================================
    // Slot register
    // A cycle of latency is traded for glitch-free slot levels
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_slot_active <= '0;
        end else begin
            irq_slot_active <= slot_nxt;
        end
    end

endmodule

// ==== logic/sirq_pkg.sv ====
// Package: register map, field layout and sizes of the serial interrupt source selector
package sirq_pkg;

    // ==========================================================
    // Sizes
    localparam int CHANNELS = 16;
    localparam int DEVICES = 64;
    localparam int ADDR_W = 8;

    // ==========================================================
    // Register map
    localparam logic [7:0] CHAN_BASE = 8'h40;
    localparam logic [7:0] CHAN_LAST = 8'h4f;
    localparam logic [7:0] FW_IRQ_OFS = 8'h50;
    localparam logic [7:0] CHAN_RESET = 8'hff;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ==========================================================
    // Channel entry fields
    localparam int LINE_SEL_BIT = 7;
    localparam int LOCATION_BIT = 6;
    localparam int DEV_LSB = 0;
    localparam int DEV_W = 6;
    localparam logic [5:0] FW_DEVICE = 6'h0c;

    typedef struct packed {
        logic line_sel;
        logic location;
        logic [5:0] device;
    } chan_entry_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

endpackage

// ==== logic/sirq_chan_mem.sv ====
// Channel entry storage with registered read data
module sirq_chan_mem
    import sirq_pkg::*;
#(
    parameter int N = CHANNELS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic host_side_reset_n,
    // Write port
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [7:0] wr_data,
    // Read port
    input wire logic [3:0] rd_idx,
    output logic [7:0] rd_data,
    // All entries for the routing logic
    output chan_entry_type [N-1:0] entries
);

    // ==========================================================
    // Storage
    logic [7:0] mem_r [N];
    logic [7:0] mem_nxt [N];
    logic [7:0] rd_data_nxt;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (wr_en) begin
            mem_nxt[wr_idx] = wr_data;
        end
        rd_data_nxt = mem_r[rd_idx];
    end

    // Entries reset to deactivated on the host-side reset
    always_ff @(posedge sys_clk or negedge host_side_reset_n) begin
        if (!host_side_reset_n) begin
            for (int i = 0; i < N; i++) begin
                mem_r[i] <= CHAN_RESET;
            end
            rd_data <= 8'h00;
        end else begin
            mem_r <= mem_nxt;
            rd_data <= rd_data_nxt;
        end
    end

    generate
        for (genvar g = 0; g < N; g++) begin : g_out
            assign entries[g] = chan_entry_type'(mem_r[g]);
        end
    endgenerate

endmodule

// ==== verif/sirq_asserts.sv ====
// Checker: slot routing and register port of the selector
module sirq_asserts
    import sirq_pkg::*;
#(
    parameter int N = CHANNELS,
    parameter logic [DEVICES-1:0] TWO_LINE_DEVICES = 64'h2
) (
    // Clock and resets
    input wire logic sys_clk, resetn, host_side_reset_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    input wire logic reg_wr, reg_rd,
    // Sources and slots
    input wire logic [DEVICES-1:0] dev_irq_first, dev_irq_second,
    input wire logic [N-1:0] irq_slot_active
);
    // ==========================================
    // Shadow of the entries, fed by the port
    logic [7:0] ent_r [N];
    logic [N-1:0] fw_r, exp_slot, off_m, fw_m;
    always_ff @(posedge sys_clk or negedge host_side_reset_n) begin
        if (!host_side_reset_n) begin
            ent_r <= '{default: CHAN_RESET};
            fw_r <= '0;
        end else if (reg_wr) begin
            if (reg_addr[7:4] == 4'h4) ent_r[reg_addr[3:0]] <= reg_wdata;
            if (reg_addr == FW_IRQ_OFS) fw_r[7:0] <= reg_wdata;
            if (reg_addr == 8'h51) fw_r[15:8] <= reg_wdata;
        end
    end
    always_comb begin
        for (int g = 0; g < N; g++) begin
            off_m[g] = ent_r[g][LOCATION_BIT];
            fw_m[g] = !off_m[g] && ent_r[g][5:0] == FW_DEVICE;
            exp_slot[g] = fw_m[g] ? fw_r[g] : !off_m[g] && (ent_r[g][LINE_SEL_BIT]
                && TWO_LINE_DEVICES[ent_r[g][5:0]] ? dev_irq_second[ent_r[g][5:0]]
                : dev_irq_first[ent_r[g][5:0]]);
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn || !host_side_reset_n);
    chk_slot_follow: assert property (irq_slot_active == $past(exp_slot))
        else $error("slot differs from selected source");
    chk_off_quiet: assert property (off_m != 0 |=> (irq_slot_active & $past(off_m)) == 0)
        else $error("disabled channel asserted");
    chk_fw_drive: assert property (fw_m != 0 |=>
        ((irq_slot_active ^ $past(fw_r)) & $past(fw_m)) == 0) else $error("firmware slot wrong");
    chk_read_entry: assert property (reg_rd && reg_addr[7:4] == 4'h4 |=>
        reg_rdata == $past(ent_r[reg_addr[3:0]])) else $error("entry read wrong");
    chk_read_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    chk_read_fw: assert property (reg_rd && reg_addr == FW_IRQ_OFS |=>
        reg_rdata == $past(fw_r[7:0])) else $error("firmware bits read wrong");
endmodule

// ==== verif/sirq_host_model.sv ====
// Host side model: samples slot levels every clock like a framer
module sirq_host_model (
    input wire logic sys_clk,
    input wire logic [15:0] slot,
    output logic [15:0] seen
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge sys_clk) seen <= slot;
endmodule

// ==== verif/tb.sv ====
// Testbench: random routing of device lines onto serial interrupt slots
module tb import sirq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    logic sys_clk = 0, resetn = 0, host_rstn = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, ent [16];
    logic [63:0] d1 = 0, d2 = 0;
    logic [15:0] slots, seen, fw = 0, s;
    int n_fail = 0, n_checks = 0;
    sirq_host_model host (.sys_clk, .slot(slots), .seen);
    serial_irq_source_select uut (.sys_clk, .resetn, .host_side_reset_n(host_rstn), .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dev_irq_first(d1), .dev_irq_second(d2),
        .irq_slot_active(slots));
    initial forever #10 sys_clk = ~sys_clk;
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        n_checks++;
        if (got !== want) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 check(reg_rdata, want);
        @(posedge sys_clk);
    endtask
    // Only device 1 has a second line; device 0c line held low so firmware alone drives it
    function automatic logic [15:0] expect_slots();
        logic [15:0] r;
        for (int g = 0; g < 16; g++)
            r[g] = ent[g][6] ? 1'b0 : ent[g][5:0] == 6'h0c ? fw[g]
                : ent[g][7] && ent[g][5:0] == 6'h01 ? d2[1] : d1[ent[g][5:0]];
        return r;
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200us;
        n_fail++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h7872bb1c));
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        host_rstn <= 1'b1;
        @(posedge sys_clk);
        for (int g = 0; g < 16; g++) begin
            ent[g] = 8'hff;
            rd(8'h40 + 8'(g), 8'hff);
        end
        rd(8'h3f, 8'h00);
        repeat (40) begin
            for (int g = 0; g < 16; g++) begin
                s = 16'($urandom);
                // bit 6 written zero to enable
                ent[g] = s[5:4] == 0 ? 8'hff : {s[7], s[3:2] == 0, s[15:14] == 0 ? 6'h0c
                    : s[15:14] == 1 ? 6'h01 : s[13:8]};
                wr(8'h40 + 8'(g), ent[g]);
            end
            fw = 16'($urandom);
            wr(8'h50, fw[7:0]);
            wr(8'h51, fw[15:8]);
            d1 <= {$urandom, $urandom} & ~64'h1000;
            d2 <= {$urandom, $urandom};
            rd(8'h40 + 8'(s[3:0]), ent[s[3:0]]);
            rd(8'h50, fw[7:0]);
            repeat (2) @(posedge sys_clk);
            #1 check(seen, expect_slots());
            @(posedge sys_clk);
        end
        // mid-run host-side reset brings entries back to FFh
        host_rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        host_rstn <= 1'b1;
        @(posedge sys_clk);
        fw = 16'h0000;
        for (int g = 0; g < 16; g++) begin
            ent[g] = 8'hff;
            rd(8'h40 + 8'(g), 8'hff);
        end
        rd(8'h51, fw[15:8]);
        #1 check(seen, 16'h0000);
        complete_run();
    end
endmodule
bind serial_irq_source_select sirq_asserts #(.N(N), .TWO_LINE_DEVICES(TWO_LINE_DEVICES)) chk (
    .sys_clk, .resetn, .host_side_reset_n, .reg_addr, .reg_wdata, .reg_rdata, .reg_wr,
    .reg_rd, .dev_irq_first, .dev_irq_second, .irq_slot_active);
